// ---- rtl/itm_defines.svh ----
// Register offsets, field positions, reset values and timing counts for the management block.
`ifndef ITM_DEFINES_SVH
`define ITM_DEFINES_SVH
`define ITM_DATA_OFFSET     8'h00A4
`define ITM_ACCESS_OFFSET   8'h00A8
`define ITM_DATA_RESET      16'h0000
`define ITM_ADDR_RESET      5'h00
`define ITM_INDEX_RESET     5'h00
`define ITM_DATA_HI         15
`define ITM_DATA_LO         0
`define ITM_ADDR_HI         15
`define ITM_ADDR_LO         11
`define ITM_INDEX_HI        10
`define ITM_INDEX_LO        6
`define ITM_DIR_BIT         1
`define ITM_BUSY_BIT        0
`define ITM_MDC_DIV         7'h28
`define ITM_MDC_DIV_LAST    7'h27
`define ITM_FRAME_BITS      6'h20
`define ITM_PREAMBLE_BITS   6'h20
`define ITM_TA_FIRST_BIT    6'h0E
`define ITM_RD_DATA_BIT     6'h10
`define ITM_PHY_COUNT       5'h02
`define ITM_PHY_FIRST       5'h01
`endif

// ---- rtl/itm_pkg.sv ----
// Types shared by the indirect transceiver management block.
package itm_pkg;
    typedef struct packed {
        logic [4:0]  phy_addr;
        logic [4:0]  reg_index;
        logic        write;
        logic [15:0] wdata;
    } itm_cmd_t;

    typedef struct packed {
        logic        done;
        logic [15:0] rdata;
    } itm_rsp_t;

    typedef enum logic [1:0] {
        ITM_IDLE     = 2'b00,
        ITM_PREAMBLE = 2'b01,
        ITM_FRAME    = 2'b11,
        ITM_FINISH   = 2'b10
    } itm_state_t;
endpackage

// ---- rtl/itm_mdio_engine.sv ----
// Serial management engine that runs one read or write frame toward a PHY.
`timescale 1ns/1ps
`include "itm_defines.svh"
module itm_mdio_engine
    import itm_pkg::*;
(
    input  wire logic            sys_clk_i,
    input  wire logic            rst_n_i,
    input  wire logic            start_i,
    input  wire itm_pkg::itm_cmd_t cmd_i,
    input  wire logic            mdio_i,
    output logic                 mdc_o,
    output logic                 mdio_o,
    output logic                 mdio_oe_o,
    output itm_pkg::itm_rsp_t    rsp_o
);
    import itm_pkg::*;

    itm_state_t  state_q,  state_d;
    logic [6:0]  div_q,    div_d;
    logic [5:0]  bit_q,    bit_d;
    logic [31:0] shift_q,  shift_d;
    logic [15:0] rdata_q,  rdata_d;
    logic        mdc_q,    mdc_d;
    logic        mdo_q,    mdo_d;
    logic        oe_q,     oe_d;
    logic        done_q,   done_d;
    logic        wr_q,     wr_d;
    logic        mdi_s1_q, mdi_s2_q;
    logic        fall_en;
    logic        rise_en;

    assign fall_en = (div_q == `ITM_MDC_DIV_LAST);
    assign rise_en = (div_q == (`ITM_MDC_DIV >> 1));

    always_comb
    begin
        state_d = state_q;
        div_d   = (div_q == `ITM_MDC_DIV_LAST) ? 7'h00 : div_q + 7'h01;
        bit_d   = bit_q;
        shift_d = shift_q;
        rdata_d = rdata_q;
        mdc_d   = mdc_q;
        mdo_d   = mdo_q;
        oe_d    = oe_q;
        done_d  = 1'b0;
        wr_d    = wr_q;
        if (state_q == ITM_IDLE)
        begin
            div_d = 7'h00;
            mdc_d = 1'b0;
        end
        else if (rise_en)
        begin
            mdc_d = 1'b1;
        end
        unique case (state_q)
            ITM_IDLE:
            begin
                oe_d = 1'b0;
                if (start_i)
                begin
                    // Clause-22 frame: start, opcode, addresses, turnaround, data.
                    shift_d = {2'b01, cmd_i.write ? 2'b01 : 2'b10, cmd_i.phy_addr,
                               cmd_i.reg_index, 2'b10, cmd_i.wdata};
                    bit_d   = `ITM_PREAMBLE_BITS;
                    wr_d    = cmd_i.write;
                    state_d = ITM_PREAMBLE;
                end
            end
            ITM_PREAMBLE:
            begin
                if (fall_en)
                begin
                    mdc_d = 1'b0;
                    oe_d  = 1'b1;
                    mdo_d = 1'b1;
                    bit_d = bit_q - 6'h01;
                    if (bit_q == 6'h01)
                    begin
                        bit_d   = `ITM_FRAME_BITS;
                        state_d = ITM_FRAME;
                    end
                end
            end
            ITM_FRAME:
            begin
                if (rise_en && !oe_q && bit_q <= `ITM_RD_DATA_BIT)
                begin
                    rdata_d = {rdata_q[14:0], mdi_s2_q};
                end
                if (fall_en)
                begin
                    mdc_d   = 1'b0;
                    bit_d   = bit_q - 6'h01;
                    mdo_d   = shift_q[31];
                    shift_d = {shift_q[30:0], 1'b0};
                    // A write keeps the line driven through turnaround and data; a read lets go.
                    oe_d    = wr_q || bit_q > (`ITM_TA_FIRST_BIT + 6'h04);
                    if (bit_q == 6'h00)
                    begin
                        oe_d    = 1'b0;
                        state_d = ITM_FINISH;
                    end
                end
            end
            ITM_FINISH:
            begin
                done_d  = 1'b1;
                state_d = ITM_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q  <= ITM_IDLE;
            div_q    <= 7'h00;
            bit_q    <= 6'h00;
            shift_q  <= 32'h0000_0000;
            rdata_q  <= `ITM_DATA_RESET;
            mdc_q    <= 1'b0;
            mdo_q    <= 1'b0;
            oe_q     <= 1'b0;
            done_q   <= 1'b0;
            wr_q     <= 1'b0;
            mdi_s1_q <= 1'b0;
            mdi_s2_q <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            div_q    <= div_d;
            bit_q    <= bit_d;
            shift_q  <= shift_d;
            rdata_q  <= rdata_d;
            mdc_q    <= mdc_d;
            mdo_q    <= mdo_d;
            oe_q     <= oe_d;
            done_q   <= done_d;
            wr_q     <= wr_d;
            mdi_s1_q <= mdio_i;
            mdi_s2_q <= mdi_s1_q;
        end
    end

    assign mdc_o       = mdc_q;
    assign mdio_o      = mdo_q;
    assign mdio_oe_o   = oe_q;
    assign rsp_o.done  = done_q;
    assign rsp_o.rdata = rdata_q;
endmodule

// ---- rtl/itm_regs.sv ----
// Register front end for indirect access to the internal PHY management registers.
`timescale 1ns/1ps
`include "itm_defines.svh"
module itm_regs
    import itm_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        mdio_i,
    output logic [31:0]      reg_rdata_o,
    output logic             mdc_o,
    output logic             mdio_o,
    output logic             mdio_oe_o
);
    import itm_pkg::*;

    logic [15:0] wr_data_q,  wr_data_d;
    logic [15:0] rd_data_q,  rd_data_d;
    logic [4:0]  phy_addr_q, phy_addr_d;
    logic [4:0]  index_q,    index_d;
    logic        dir_q,      dir_d;
    logic        busy_q,     busy_d;
    logic        start_q,    start_d;
    logic [31:0] rdata_q,    rdata_d;
    itm_cmd_t    cmd;
    itm_rsp_t    rsp;
    logic        mdc_w, mdo_w, oe_w;

    // Only the real PHY addresses are reachable; the emulated PHY never answers here.
    function automatic logic itm_real_phy(input logic [4:0] addr);
        itm_real_phy = (addr >= `ITM_PHY_FIRST) && (addr < (`ITM_PHY_FIRST + `ITM_PHY_COUNT));
    endfunction

    function automatic logic itm_hit(input logic [7:0] addr, input logic [7:0] offs);
        itm_hit = (addr == offs);
    endfunction

    always_comb
    begin
        wr_data_d  = wr_data_q;
        rd_data_d  = rd_data_q;
        phy_addr_d = phy_addr_q;
        index_d    = index_q;
        dir_d      = dir_q;
        busy_d     = busy_q;
        start_d    = 1'b0;
        rdata_d    = rdata_q;
        if (reg_wr_i && itm_hit(reg_addr_i, `ITM_DATA_OFFSET))
        begin
            wr_data_d = reg_wdata_i[`ITM_DATA_HI:`ITM_DATA_LO];
        end
        if (rsp.done)
        begin
            busy_d = 1'b0;
            if (!dir_q)
            begin
                rd_data_d = rsp.rdata;
            end
        end
        if (reg_wr_i && itm_hit(reg_addr_i, `ITM_ACCESS_OFFSET))
        begin
            phy_addr_d = reg_wdata_i[`ITM_ADDR_HI:`ITM_ADDR_LO];
            index_d    = reg_wdata_i[`ITM_INDEX_HI:`ITM_INDEX_LO];
            dir_d      = reg_wdata_i[`ITM_DIR_BIT];
            if (itm_real_phy(reg_wdata_i[`ITM_ADDR_HI:`ITM_ADDR_LO]))
            begin
                busy_d  = 1'b1;
                start_d = 1'b1;
            end
        end
        if (reg_rd_i)
        begin
            rdata_d = 32'h0000_0000;
            if (itm_hit(reg_addr_i, `ITM_DATA_OFFSET))
            begin
                rdata_d[`ITM_DATA_HI:`ITM_DATA_LO] = dir_q ? wr_data_q : rd_data_q;
            end
            else if (itm_hit(reg_addr_i, `ITM_ACCESS_OFFSET))
            begin
                rdata_d[`ITM_ADDR_HI:`ITM_ADDR_LO]   = phy_addr_q;
                rdata_d[`ITM_INDEX_HI:`ITM_INDEX_LO] = index_q;
                rdata_d[`ITM_DIR_BIT]                = dir_q;
                rdata_d[`ITM_BUSY_BIT]               = busy_q;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_data_q  <= `ITM_DATA_RESET;
            rd_data_q  <= `ITM_DATA_RESET;
            phy_addr_q <= `ITM_ADDR_RESET;
            index_q    <= `ITM_INDEX_RESET;
            dir_q      <= 1'b0;
            busy_q     <= 1'b0;
            start_q    <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            mdc_o      <= 1'b0;
            mdio_o     <= 1'b0;
            mdio_oe_o  <= 1'b0;
        end
        else
        begin
            wr_data_q  <= wr_data_d;
            rd_data_q  <= rd_data_d;
            phy_addr_q <= phy_addr_d;
            index_q    <= index_d;
            dir_q      <= dir_d;
            busy_q     <= busy_d;
            start_q    <= start_d;
            rdata_q    <= rdata_d;
            mdc_o      <= mdc_w;
            mdio_o     <= mdo_w;
            mdio_oe_o  <= oe_w;
        end
    end

    assign reg_rdata_o   = rdata_q;
    assign cmd.phy_addr  = phy_addr_q;
    assign cmd.reg_index = index_q;
    assign cmd.write     = dir_q;
    assign cmd.wdata     = wr_data_q;

    // The captured fields drive one frame per launched access.
    itm_mdio_engine u_engine (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .start_i   (start_q),
        .cmd_i     (cmd),
        .mdio_i    (mdio_i),
        .mdc_o     (mdc_w),
        .mdio_o    (mdo_w),
        .mdio_oe_o (oe_w),
        .rsp_o     (rsp)
    );
endmodule

// ---- sim/itm_phy_model.sv ----
// Behavioural model of the two PHY management register sets.
`timescale 1ns/1ps
module itm_phy_model (
    input  wire logic mdc_i,
    input  wire logic mdio_i,
    output logic      drive_o,
    output logic      data_o
);
    logic [15:0] mem [2][32];
    logic [5:0]  ones;
    logic [5:0]  n;
    logic [11:0] hdr;
    logic [15:0] sh;
    int          frames;
    wire         hit = hdr[9:5] == 5'h01 || hdr[9:5] == 5'h02;
    wire         rd  = hdr[11:10] == 2'b10;
    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i / 32][i % 32] = {6'h2a, 5'(i / 32 + 1), 5'(i % 32)};
        ones = 6'h00;
        n = 6'h00;
        frames = 0;
        drive_o = 1'b0;
        data_o = 1'b1;
    end
    // Bit n counts from the start bit; the preamble is only counted.
    always @(posedge mdc_i)
    begin
        if (n == 6'h00)
        begin
            if (!mdio_i && ones >= 6'h20)
                n <= 6'h01;
            ones <= mdio_i ? ones + {5'h00, ones != 6'h3f} : 6'h00;
        end
        else
        begin
            n <= (n == 6'h1f) ? 6'h00 : n + 6'h01;
            if (n <= 6'h0d)
                hdr <= {hdr[10:0], mdio_i};
            sh <= {sh[14:0], mdio_i};
            if (n == 6'h1f)
            begin
                frames++;
                if (hit && hdr[11:10] == 2'b01)
                    mem[hdr[9:5] - 5'h01][hdr[4:0]] <= {sh[14:0], mdio_i};
            end
        end
    end
    // Only a present PHY answers a read, from the second turnaround bit on.
    always @(negedge mdc_i)
    begin
        drive_o <= rd && hit && n >= 6'h0f;
        data_o  <= n >= 6'h10 ? mem[hdr[9:5] - 5'h01][hdr[4:0]][6'h1f - n] : 1'b0;
    end
endmodule

// ---- sim/itm_regs_sva.sv ----
// Port checker for the indirect PHY management registers.
`timescale 1ns/1ps
`include "itm_defines.svh"
module itm_regs_sva (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic        mdio_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        mdc_o,
    input wire logic        mdio_o,
    input wire logic        mdio_oe_o
);
    logic [6:0] idle_q;
    logic       dir_q;
    wire acc_wr = reg_wr_i && reg_addr_i == `ITM_ACCESS_OFFSET;
    wire acc_rd = reg_rd_i && reg_addr_i == `ITM_ACCESS_OFFSET;
    wire dat_wr = reg_wr_i && reg_addr_i == `ITM_DATA_OFFSET;
    wire dat_rd = reg_rd_i && reg_addr_i == `ITM_DATA_OFFSET;
    wire ok_phy = reg_wdata_i[15:11] == 5'h01 || reg_wdata_i[15:11] == 5'h02;
    wire quiet  = idle_q == 7'h7f;
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            idle_q <= 7'h7f;
            dir_q  <= 1'b0;
        end
        else
        begin
            idle_q <= (mdc_o || acc_wr) ? 7'h00 : idle_q + {6'h00, !quiet};
            dir_q  <= acc_wr ? reg_wdata_i[1] : dir_q;
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    start_frame_a: assert property (acc_wr && ok_phy && quiet |-> ##[1:60] mdc_o)
        else $error("access write started no frame");
    bad_phy_a: assert property (acc_wr && !ok_phy && quiet |=> !mdc_o [*8])
        else $error("frame toward absent PHY");
    busy_set_a: assert property (acc_wr && ok_phy ##2 acc_rd |=> reg_rdata_o[0])
        else $error("busy not set");
    fields_a: assert property (acc_wr ##2 acc_rd |=> reg_rdata_o[15:1] ==
        {$past(reg_wdata_i[15:6], 3), 4'h0, $past(reg_wdata_i[1], 3)}) else $error("bad fields");
    upper_zero_a: assert property (reg_rd_i |=> reg_rdata_o[31:16] == 16'h0000)
        else $error("upper bits not zero");
    data_back_a: assert property (dat_wr && dir_q ##2 dat_rd |=>
        reg_rdata_o[15:0] == $past(reg_wdata_i[15:0], 3)) else $error("data not returned");
    busy_clear_a: assert property (quiet && acc_rd |=> !reg_rdata_o[0])
        else $error("busy stuck");
    mdc_half_a: assert property ($rose(mdc_o) |->
        mdc_o [*8] ##1 mdc_o [*8] ##1 mdc_o [*3] ##1 !mdc_o) else $error("bad clock");
    cover property (acc_wr && ok_phy && reg_wdata_i[1]);
    cover property (acc_wr && ok_phy && !reg_wdata_i[1]);
    cover property (acc_wr && !ok_phy);
endmodule

// ---- sim/test_indirect_phy_register_access.sv ----
// Self-checking bench for the indirect PHY management registers.
`timescale 1ns/1ps
`include "itm_defines.svh"
module test_indirect_phy_register_access;
    logic        sys_clk_i;
    logic        rst_n_i;
    logic [7:0]  reg_addr_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [31:0] reg_wdata_i;
    logic        mdio_i;
    logic [31:0] reg_rdata_o;
    logic        mdc_o;
    logic        mdio_o;
    logic        mdio_oe_o;
    logic        phy_drv;
    logic        phy_dat;
    int          err_count = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          rises = 0;
    // The management line has a pull-up, so it reads high when nobody drives it.
    assign mdio_i = mdio_oe_o ? mdio_o : (phy_drv ? phy_dat : 1'b1);
    itm_regs DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .mdio_i(mdio_i), .reg_rdata_o(reg_rdata_o), .mdc_o(mdc_o), .mdio_o(mdio_o),
        .mdio_oe_o(mdio_oe_o));
    itm_phy_model phy (.mdc_i(mdc_o), .mdio_i(mdio_i), .drive_o(phy_drv), .data_o(phy_dat));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge sys_clk_i);
        d = reg_rdata_o;
    endtask
    task automatic wait_idle(output logic [31:0] d);
        int k = 0;
        reg_read(`ITM_ACCESS_OFFSET, d);
        while (d[0] !== 1'b0 && k < 3000)
        begin
            k++;
            reg_read(`ITM_ACCESS_OFFSET, d);
        end
    endtask
    task automatic t_reset();
        logic [31:0] d;
        reg_read(`ITM_DATA_OFFSET, d);
        check(d, 32'h0000_0000);
        reg_read(`ITM_ACCESS_OFFSET, d);
        check(d, 32'h0000_0000);
    endtask
    task automatic t_bad(input logic [4:0] p);
        logic [31:0] d;
        int          m;
        m = rises;
        reg_write(`ITM_ACCESS_OFFSET, {16'h0000, p, 11'h0c3});
        reg_read(`ITM_ACCESS_OFFSET, d);
        check(d, {16'h0000, p, 11'h0c2});
        repeat (200) @(posedge sys_clk_i);
        check(32'(rises), 32'(m));
    endtask
    task automatic t_xfer(input logic [4:0] p, input logic [4:0] r, input logic w,
                          input logic [15:0] v);
        logic [31:0] a;
        logic [31:0] d;
        int          f;
        a = {16'h0000, p, r, 4'h0, w, 1'b0};
        if (w)
            reg_write(`ITM_DATA_OFFSET, {16'h0000, v});
        f = phy.frames;
        reg_write(`ITM_ACCESS_OFFSET, a);
        reg_read(`ITM_ACCESS_OFFSET, d);
        check(d, a | 32'h0000_0001);
        wait_idle(d);
        check(d, a);
        check(32'(phy.frames), 32'(f + 1));
        reg_read(`ITM_DATA_OFFSET, d);
        check(d, {16'h0000, v});
        check({16'h0000, phy.mem[p - 5'h01][r]}, {16'h0000, v});
    endtask
    task automatic t_back();
        logic [31:0] d;
        reg_write(`ITM_DATA_OFFSET, 32'hffff_1234);
        reg_read(`ITM_DATA_OFFSET, d);
        check(d, 32'h0000_1234);
    endtask
    always @(posedge mdc_o)
        rises++;
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_count++;
            print_verdict();
        end
    end
    initial
    begin
        rst_n_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wdata_i = 32'h0000_0000;
        repeat (3) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        @(posedge sys_clk_i);
        t_reset();
        t_bad(5'h00);
        t_bad(5'h03);
        t_xfer(5'h01, 5'h00, 1'b1, 16'ha5c3);
        t_back();
        t_xfer(5'h02, 5'h1f, 1'b1, 16'h5a3c);
        t_xfer(5'h01, 5'h00, 1'b0, 16'ha5c3);
        t_xfer(5'h02, 5'h1f, 1'b0, 16'h5a3c);
        t_xfer(5'h01, 5'h1f, 1'b0, {6'h2a, 5'h01, 5'h1f});
        print_verdict();
    end
endmodule
bind itm_regs itm_regs_sva chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .mdio_i(mdio_i), .reg_rdata_o(reg_rdata_o),
    .mdc_o(mdc_o), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o));
